/* rtl/smrsc_regs.vh */
`ifndef SMRSC_REGS_VH
`define SMRSC_REGS_VH
// ======================================================
// register byte offsets
// ======================================================
`define SMRSC_OFS_SPD_GAIN 8'h00
`define SMRSC_OFS_SPD_OFFSET 8'h04
`define SMRSC_OFS_SPD_MAX 8'h08
`define SMRSC_OFS_TRQ_GAIN 8'h0c
`define SMRSC_OFS_TRQ_OFFSET 8'h10
`define SMRSC_OFS_TRQ_MAX 8'h14
`define SMRSC_OFS_CONFIG 8'h18
`define SMRSC_OFS_STATUS 8'h1c
`define SMRSC_OFS_COMMAND 8'h20
// ======================================================
// reset values
// ======================================================
`define SMRSC_RST_SPD_GAIN 12'h352
`define SMRSC_RST_SPD_OFFSET 12'h000
`define SMRSC_RST_SPD_MAX 12'hfa0
`define SMRSC_RST_TRQ_GAIN 8'h36
`define SMRSC_RST_TRQ_OFFSET 7'h00
`define SMRSC_RST_TRQ_MAX 8'hfa
`define SMRSC_RST_STOP_ACT 2'h0
`define SMRSC_RST_POST_STOP 1'h0
`define SMRSC_RST_DIR_CW 1'h1
`define SMRSC_RST_SRC_SEL 2'h1
// ======================================================
// config register fields
// ======================================================
`define SMRSC_CFG_STOP_ACT 1:0
`define SMRSC_CFG_POST_STOP 2
`define SMRSC_CFG_DIR_CW 3
`define SMRSC_CFG_SRC_SEL 5:4
// source select encodings and stop action bits
`define SMRSC_SRC_DIGITAL 2'h0
`define SMRSC_SRC_ANA_SPD 2'h1
`define SMRSC_SRC_ANA_TRQ 2'h2
`define SMRSC_STOP_DECEL_BIT 0
`define SMRSC_STOP_CUROFF_BIT 1
// ======================================================
// timing
// ======================================================
`define SMRSC_CLK_HZ 40000000
`define SMRSC_T_FILT_MS 10
`define SMRSC_FILT_CYC (`SMRSC_T_FILT_MS * `SMRSC_CLK_HZ / 1000)
`define SMRSC_MV_PER_V 1000
`endif

/* rtl/smrsc_top.v */
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "smrsc_regs.vh"
module smrsc_top #(
    parameter FILT_CYC = `SMRSC_FILT_CYC, // input hold time in cycles
    parameter NTL = 2, // terminals able to carry torque enable
    parameter [7:0] TRQ_PEAK = 8'hfa // limit shown when limiting is off
) (
    input wire i_ref_clk,
    input wire i_rst_b,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    input wire [13:0] i_analog_mv,
    input wire [13:0] i_pot_mv,
    input wire i_data_select_bit0_input,
    input wire [11:0] i_digital_speed,
    input wire [7:0] i_digital_torque,
    input wire i_forward_run_input,
    input wire i_reverse_run_input,
    input wire i_stop_input,
    input wire [NTL-1:0] i_torque_limit_enable_input,
    input wire [NTL-1:0] i_trq_en_assigned,
    output reg o_motor_run,
    output reg o_dir_cw,
    output reg o_decel,
    output reg o_current_off,
    output reg o_servo_lock,
    output reg [11:0] o_speed_cmd,
    output reg [7:0] o_torque_limit,
    output reg o_torque_limit_en
);
// ======================================================
// state codes
// ======================================================
localparam [1:0] ST_IDLE = 2'h0; // stopped, no command
localparam [1:0] ST_RUN = 2'h1; // running in one direction
localparam [1:0] ST_DECEL = 2'h2; // ramping down to standstill
localparam [1:0] ST_HALT = 2'h3; // stopped by the stop input
localparam CW = 20; // filter counter width

// ======================================================
// registers
// ======================================================
reg [11:0] spd_gain_reg; // r/min per volt
reg [11:0] spd_offset_reg; // signed r/min
reg [11:0] spd_max_reg; // r/min ceiling
reg [7:0] trq_gain_reg; // percent per volt
reg [6:0] trq_offset_reg; // signed percent
reg [7:0] trq_max_reg; // percent ceiling
reg [1:0] stop_act_reg; // stop input action
reg post_stop_reg; // written value, read back only, never used
reg dir_cw_reg; // written value, read back only, never used
reg [1:0] src_sel_reg; // speed / torque source
reg post_stop_act_reg; // value in force
reg dir_cw_act_reg; // value in force
reg loaded_reg; // power-on copy has been taken
reg [1:0] state_reg; // run state
reg [1:0] state_next;
reg fwd_reg; // direction of the present run
wire [2:0] filt_lvl; // qualified stop, rev, fwd
wire [2:0] raw_in; // unfiltered control inputs
wire acc; // apb access phase
wire wr; // write takes effect this edge
reg map_ok; // address decodes to a register
reg [31:0] rd_mux; // read data before the flop

assign raw_in = {i_stop_input, i_reverse_run_input, i_forward_run_input};
assign acc = i_psel & i_penable;
assign wr = acc & i_pwrite & map_ok;
assign o_pready = 1'b1; // no wait states
assign o_pslverr = acc & ~map_ok;

// ======================================================
// input qualification
// ======================================================
// a level is accepted once it has held steady for FILT_CYC
// cycles; short glitches from contacts never reach the fsm
genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_filt
        reg [CW-1:0] cnt_reg; // cycles at a differing level
        reg lvl_reg; // accepted level of this input
        always @(posedge i_ref_clk) begin
            if (!i_rst_b) begin
                cnt_reg <= {CW{1'b0}};
                lvl_reg <= 1'b0;
            end else if (raw_in[gi] == lvl_reg) begin
                cnt_reg <= {CW{1'b0}}; // steady, rearm
            end else if (cnt_reg >= FILT_CYC[CW-1:0] - 1'b1) begin
                cnt_reg <= {CW{1'b0}};
                lvl_reg <= raw_in[gi]; // held long enough
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
        assign filt_lvl[gi] = lvl_reg;
    end
endgenerate

// ======================================================
// apb decode and read mux
// ======================================================
always @* begin
    map_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    case (i_paddr)
        `SMRSC_OFS_SPD_GAIN: rd_mux[11:0] = spd_gain_reg;
        `SMRSC_OFS_SPD_OFFSET: rd_mux[11:0] = spd_offset_reg;
        `SMRSC_OFS_SPD_MAX: rd_mux[11:0] = spd_max_reg;
        `SMRSC_OFS_TRQ_GAIN: rd_mux[7:0] = trq_gain_reg;
        `SMRSC_OFS_TRQ_OFFSET: rd_mux[6:0] = trq_offset_reg;
        `SMRSC_OFS_TRQ_MAX: rd_mux[7:0] = trq_max_reg;
        `SMRSC_OFS_CONFIG: rd_mux[5:0] = {src_sel_reg, dir_cw_reg,
            post_stop_reg, stop_act_reg};
        `SMRSC_OFS_STATUS: rd_mux[12:0] = {filt_lvl, post_stop_act_reg,
            dir_cw_act_reg, state_reg, o_motor_run, o_dir_cw, o_decel,
            o_current_off, o_servo_lock, o_torque_limit_en};
        `SMRSC_OFS_COMMAND: rd_mux[19:0] = {o_torque_limit, o_speed_cmd};
        default: map_ok = 1'b0; // unmapped reads zero with error
    endcase
end

// read data is captured in the setup cycle so it is a flop output
always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
        o_prdata <= 32'h0000_0000;
    end else if (i_psel & ~i_penable & ~i_pwrite) begin
        o_prdata <= rd_mux;
    end
end

// ======================================================
// register writes
// ======================================================
always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
        spd_gain_reg <= `SMRSC_RST_SPD_GAIN;
        spd_offset_reg <= `SMRSC_RST_SPD_OFFSET;
        spd_max_reg <= `SMRSC_RST_SPD_MAX;
        trq_gain_reg <= `SMRSC_RST_TRQ_GAIN;
        trq_offset_reg <= `SMRSC_RST_TRQ_OFFSET;
        trq_max_reg <= `SMRSC_RST_TRQ_MAX;
        stop_act_reg <= `SMRSC_RST_STOP_ACT;
        post_stop_reg <= `SMRSC_RST_POST_STOP;
        dir_cw_reg <= `SMRSC_RST_DIR_CW;
        src_sel_reg <= `SMRSC_RST_SRC_SEL;
    end else if (wr) begin
        case (i_paddr)
            `SMRSC_OFS_SPD_GAIN: spd_gain_reg <= i_pwdata[11:0];
            `SMRSC_OFS_SPD_OFFSET: spd_offset_reg <= i_pwdata[11:0];
            `SMRSC_OFS_SPD_MAX: spd_max_reg <= i_pwdata[11:0];
            `SMRSC_OFS_TRQ_GAIN: trq_gain_reg <= i_pwdata[7:0];
            `SMRSC_OFS_TRQ_OFFSET: trq_offset_reg <= i_pwdata[6:0];
            `SMRSC_OFS_TRQ_MAX: trq_max_reg <= i_pwdata[7:0];
            `SMRSC_OFS_CONFIG: begin
                stop_act_reg <= i_pwdata[`SMRSC_CFG_STOP_ACT];
                post_stop_reg <= i_pwdata[`SMRSC_CFG_POST_STOP];
                dir_cw_reg <= i_pwdata[`SMRSC_CFG_DIR_CW];
                src_sel_reg <= i_pwdata[`SMRSC_CFG_SRC_SEL];
            end
            default: ; // read-only or unmapped, nothing stored
        endcase
    end
end

// ======================================================
// power-on copy of restart-only settings
// ======================================================
// direction and hold mode are taken once, on the first edge after
// reset, from their reset values; writes never reach them, so a running motor
// never flips direction under software
always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
        loaded_reg <= 1'b0;
        post_stop_act_reg <= `SMRSC_RST_POST_STOP;
        dir_cw_act_reg <= `SMRSC_RST_DIR_CW;
    end else if (!loaded_reg) begin
        loaded_reg <= 1'b1;
        post_stop_act_reg <= post_stop_reg;
        dir_cw_act_reg <= dir_cw_reg;
    end
end

// ======================================================
// speed and torque scaling
// ======================================================
// select bit low picks the built-in pot, high the external voltage
wire [13:0] ana_mv = i_data_select_bit0_input ? i_analog_mv : i_pot_mv;
wire [25:0] spd_prod = spd_gain_reg * ana_mv;
wire [21:0] trq_prod = trq_gain_reg * ana_mv;
wire [31:0] spd_quot = spd_prod / `SMRSC_MV_PER_V;
wire [31:0] trq_quot = trq_prod / `SMRSC_MV_PER_V;
// cut wide enough that even a full-scale 14-bit input never wraps
wire [16:0] spd_scaled = spd_quot[16:0];
wire [12:0] trq_scaled = trq_quot[12:0];
// sign-extended sums, wide enough never to wrap
wire signed [17:0] spd_sum = $signed({1'b0, spd_scaled})
    + $signed({{6{spd_offset_reg[11]}}, spd_offset_reg});
wire signed [13:0] trq_sum = $signed({1'b0, trq_scaled})
    + $signed({{7{trq_offset_reg[6]}}, trq_offset_reg});
reg [11:0] spd_ana; // clamped analog speed
reg [7:0] trq_ana; // clamped analog torque
wire trq_lim_on = &(i_torque_limit_enable_input | ~i_trq_en_assigned);

always @* begin
    if (spd_sum < 0) begin
        spd_ana = 12'h000;
    end else if (spd_sum > $signed({6'h00, spd_max_reg})) begin
        spd_ana = spd_max_reg;
    end else begin
        spd_ana = spd_sum[11:0];
    end
    if (trq_sum < 0) begin
        trq_ana = 8'h00;
    end else if (trq_sum > $signed({6'h00, trq_max_reg})) begin
        trq_ana = trq_max_reg;
    end else begin
        trq_ana = trq_sum[7:0];
    end
end

// source select picks what feeds the power stage
always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
        o_speed_cmd <= 12'h000;
        o_torque_limit <= TRQ_PEAK;
        o_torque_limit_en <= 1'b0;
    end else begin
        o_speed_cmd <= (src_sel_reg == `SMRSC_SRC_ANA_SPD)
            ? spd_ana : i_digital_speed;
        o_torque_limit_en <= trq_lim_on;
        if (!trq_lim_on) begin
            o_torque_limit <= TRQ_PEAK; // limiting off
        end else if (src_sel_reg == `SMRSC_SRC_ANA_TRQ) begin
            o_torque_limit <= trq_ana;
        end else begin
            o_torque_limit <= i_digital_torque;
        end
    end
end

// ======================================================
// run / stop state machine
// ======================================================
wire fwd_q = filt_lvl[0];
wire rev_q = filt_lvl[1];
wire stop_q = filt_lvl[2];

// stop input outranks the run inputs; both run inputs is a stop
always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_IDLE: begin
            if (stop_q) begin
                state_next = ST_HALT;
            end else if (fwd_q ^ rev_q) begin
                state_next = ST_RUN;
            end
        end
        ST_RUN: begin
            if (stop_q) begin
                state_next = ST_HALT;
            end else if (fwd_q & rev_q) begin
                state_next = ST_DECEL;
            end else if (fwd_reg ? !fwd_q : !rev_q) begin
                state_next = ST_DECEL; // released
            end
        end
        ST_DECEL: begin
            if (stop_q) begin
                state_next = ST_HALT;
            end else if (!fwd_q & !rev_q) begin
                state_next = ST_IDLE;
            end
        end
        ST_HALT: begin
            if (!stop_q) begin
                state_next = ST_IDLE;
            end
        end
        default: state_next = ST_IDLE;
    endcase
end

// the ramp itself lives in the power stage; it is told via o_decel
always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
        state_reg <= ST_IDLE;
        fwd_reg <= 1'b1;
        o_motor_run <= 1'b0;
        o_dir_cw <= `SMRSC_RST_DIR_CW;
        o_decel <= 1'b0;
        o_current_off <= 1'b1;
        o_servo_lock <= 1'b0;
    end else begin
        state_reg <= state_next;
        if (state_reg != ST_RUN && state_next == ST_RUN) begin
            fwd_reg <= fwd_q; // latch direction on start
            // positive direction follows the power-on copy
            o_dir_cw <= fwd_q ? dir_cw_act_reg : !dir_cw_act_reg;
        end
        o_motor_run <= (state_next == ST_RUN);
        case (state_next)
            ST_RUN: begin
                o_decel <= 1'b0;
                o_current_off <= 1'b0;
                o_servo_lock <= 1'b0;
            end
            ST_DECEL: begin
                o_decel <= 1'b1;
                o_current_off <= 1'b0;
                o_servo_lock <= 1'b0;
            end
            ST_HALT: begin
                // bit0 picks ramp or instant, bit1 drops current
                o_decel <= stop_act_reg[`SMRSC_STOP_DECEL_BIT];
                o_current_off <= stop_act_reg[`SMRSC_STOP_CUROFF_BIT]
                    | !post_stop_act_reg;
                o_servo_lock <= !stop_act_reg[`SMRSC_STOP_CUROFF_BIT]
                    & post_stop_act_reg;
            end
            default: begin
                // standstill: free run or holding torque
                o_decel <= 1'b0;
                o_current_off <= !post_stop_act_reg;
                o_servo_lock <= post_stop_act_reg;
            end
        endcase
    end
end

endmodule // smrsc_top

/* verification/smrsc_ctrl_model.sv */
`timescale 1ns/1ps
// ==========================================
// controller model for the discrete inputs
// ==========================================
module smrsc_ctrl_model #(
    parameter HOLD = 8 // minimum level time in cycles
) (
    input wire i_ref_clk,
    input wire [2:0] i_want, // {stop, reverse, forward} wished for
    output reg [2:0] o_pins // {stop, reverse, forward} on the pins
);
    integer age [0:3]; // cycles since each pin last moved, 3 is spare
    integer k;
    initial begin
        o_pins = 3'h0;
        for (k = 0; k < 4; k = k + 1) age[k] = HOLD;
    end
    // a pin moves only once it has stood long enough; a run pin rises
    // only when the other run pin is on or has rested long enough
    always @(posedge i_ref_clk) begin
        for (k = 0; k < 3; k = k + 1) begin
            if (o_pins[k] != i_want[k] && age[k] >= HOLD && (k == 2 ||
                !i_want[k] || o_pins[k ^ 1] || age[k ^ 1] >= HOLD)) begin
                o_pins[k] <= i_want[k];
                age[k] <= 0;
            end else begin
                age[k] <= age[k] + 1;
            end
        end
    end
endmodule // smrsc_ctrl_model

/* verification/smrsc_top_props.sv */
`timescale 1ns/1ps
// ==========================================
// checker on the run and limit outputs
// ==========================================
module smrsc_top_props #(
    parameter FILT_CYC = 8,
    parameter NTL = 2,
    parameter [7:0] TRQ_PEAK = 8'hfa
) (
    input wire i_ref_clk,
    input wire i_rst_b,
    input wire i_forward_run_input,
    input wire i_reverse_run_input,
    input wire i_stop_input,
    input wire [NTL-1:0] i_torque_limit_enable_input,
    input wire [NTL-1:0] i_trq_en_assigned,
    input wire o_motor_run,
    input wire o_dir_cw,
    input wire o_current_off,
    input wire o_servo_lock,
    input wire [7:0] o_torque_limit,
    input wire o_torque_limit_en
);
    reg [19:0] one_cnt; // cycles with exactly one run input on
    reg [19:0] two_cnt; // cycles with both run inputs on
    reg [19:0] stp_cnt; // cycles with stop on
    // saturate so a long level never wraps back to a small count;
    // wide enough for the full-length hold filter
    function [19:0] sat(input [19:0] c, input e);
        sat = !e ? 20'h0 : (&c ? c : c + 20'h1);
    endfunction
    always @(posedge i_ref_clk) begin
        one_cnt <= !i_rst_b ? 20'h0 :
            sat(one_cnt, i_forward_run_input ^ i_reverse_run_input);
        two_cnt <= !i_rst_b ? 20'h0 :
            sat(two_cnt, i_forward_run_input & i_reverse_run_input);
        stp_cnt <= !i_rst_b ? 20'h0 : sat(stp_cnt, i_stop_input);
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_run_start;
        !o_motor_run ##1 o_motor_run;
    endsequence
    run_filter_a: assert property (
        s_run_start |-> one_cnt >= FILT_CYC)
        else $error("run started on a short input");
    both_stop_a: assert property (
        two_cnt >= FILT_CYC + 3 |-> !o_motor_run)
        else $error("running with both inputs on");
    stop_halt_a: assert property (
        stp_cnt >= FILT_CYC + 3 |-> !o_motor_run)
        else $error("running with stop on");
    run_power_a: assert property (
        o_motor_run |-> !o_current_off && !o_servo_lock)
        else $error("run without current");
    hold_excl_a: assert property (
        !(o_servo_lock && o_current_off))
        else $error("lock with current off");
    dir_hold_a: assert property (
        o_motor_run && $past(o_motor_run) |-> $stable(o_dir_cw))
        else $error("direction moved while running");
    lim_gate_a: assert property (
        !(&(i_torque_limit_enable_input | ~i_trq_en_assigned))
        |=> !o_torque_limit_en)
        else $error("limit on with enable off");
    lim_peak_a: assert property (
        !o_torque_limit_en |-> o_torque_limit == TRQ_PEAK)
        else $error("peak not shown when off");
endmodule // smrsc_top_props
bind smrsc_top smrsc_top_props #(.FILT_CYC(FILT_CYC), .NTL(NTL),
    .TRQ_PEAK(TRQ_PEAK)) u_props (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_forward_run_input(i_forward_run_input),
    .i_reverse_run_input(i_reverse_run_input), .i_stop_input(i_stop_input),
    .i_torque_limit_enable_input(i_torque_limit_enable_input),
    .i_trq_en_assigned(i_trq_en_assigned), .o_motor_run(o_motor_run),
    .o_dir_cw(o_dir_cw), .o_current_off(o_current_off),
    .o_servo_lock(o_servo_lock), .o_torque_limit(o_torque_limit),
    .o_torque_limit_en(o_torque_limit_en));

/* verification/speed_mode_run_stop_control_test.sv */
`timescale 1ns/1ps
// ==========================================
// self-checking bench
// ==========================================
module speed_mode_run_stop_control_test;
    localparam FILT = 8; // short filter keeps the run brief
    reg clk = 1'b0;
    reg rst_b, psel, pen, pwr, msel;
    reg [7:0] addr, dtrq;
    reg [31:0] wdat, rd;
    reg [13:0] amv, pmv;
    reg [11:0] dspd;
    reg [1:0] tlen, tlasg;
    reg [2:0] want;
    reg rerr, en;
    wire [31:0] rdat;
    wire rdy, err, run, cw, dec, coff, lock, tlon;
    wire [2:0] pins;
    wire [11:0] spd;
    wire [7:0] trq;
    integer failures = 0, total_checks = 0, seed = 59312, n, i;
    integer g, o, x, tg, to, tx, mv, es, et;
    always #12.5 clk = ~clk;
    smrsc_top #(.FILT_CYC(FILT)) i_dut (.i_ref_clk(clk), .i_rst_b(rst_b),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
        .i_pwdata(wdat), .o_prdata(rdat), .o_pready(rdy), .o_pslverr(err),
        .i_analog_mv(amv), .i_pot_mv(pmv), .i_data_select_bit0_input(msel),
        .i_digital_speed(dspd), .i_digital_torque(dtrq),
        .i_forward_run_input(pins[0]), .i_reverse_run_input(pins[1]),
        .i_stop_input(pins[2]), .i_torque_limit_enable_input(tlen),
        .i_trq_en_assigned(tlasg), .o_motor_run(run), .o_dir_cw(cw),
        .o_decel(dec), .o_current_off(coff), .o_servo_lock(lock),
        .o_speed_cmd(spd), .o_torque_limit(trq), .o_torque_limit_en(tlon));
    smrsc_ctrl_model #(.HOLD(FILT)) i_ctl (.i_ref_clk(clk), .i_want(want),
        .o_pins(pins));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        total_checks = total_checks + 1;
        if (v !== e) begin
            failures = failures + 1;
            $display("BAD %s expected %h seen %h", nm, e, v);
        end
    endtask
    // one apb transfer; waits on pready, never on a fixed count
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        rd = rdat;
        rerr = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task chk_reg(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // ask the controller for levels, then wait for the run output
    task go(input logic [2:0] w, input logic r);
        want <= w;
        n = 0;
        @(posedge clk);
        while (run !== r && n < 80) begin
            @(posedge clk);
            n = n + 1;
        end
        chk("run", r, run);
    endtask
    function integer scl(input integer gn, m, of, mx);
        integer v;
        v = gn * m / 1000 + of;
        if (v < 0) v = 0;
        if (v > mx) v = mx;
        scl = v;
    endfunction
    task test_done;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        failures = failures + 1;
        test_done;
    end
    initial begin
        {rst_b, psel, pen, pwr, msel, addr, wdat, amv, pmv} = 0;
        {dspd, dtrq, tlen, tlasg, want} = 0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        chk_reg("spd gain", 8'h00, 32'd850);
        chk_reg("spd ofs", 8'h04, 32'd0);
        chk_reg("spd max", 8'h08, 32'd4000);
        chk_reg("trq gain", 8'h0c, 32'd54);
        chk_reg("trq ofs", 8'h10, 32'd0);
        chk_reg("trq max", 8'h14, 32'd250);
        chk_reg("config", 8'h18, 32'h18);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 1, rerr);
        go(3'b001, 1'b1);
        chk("fwd cw", 1, cw);
        go(3'b000, 1'b0);
        chk("rel decel", 1, dec);
        apb(1'b1, 8'h18, 32'h10); // direction write never takes effect
        go(3'b010, 1'b1);
        chk("rev dir", 0, cw);
        go(3'b000, 1'b0);
        go(3'b001, 1'b1);
        chk("dir kept", 1, cw);
        go(3'b011, 1'b0);
        chk("both decel", 1, dec);
        repeat (3 * FILT) @(posedge clk);
        chk("both idle", 0, run);
        go(3'b000, 1'b0);
        for (i = 0; i < 4; i = i + 1) begin
            apb(1'b1, 8'h18, 32'h1c | i); // lock written, never goes live
            go(3'b001, 1'b1);
            go(3'b101, 1'b0);
            chk("stop decel", i % 2, dec);
            repeat (3) @(posedge clk);
            chk("stop coff", 1, coff);
            chk("no lock", 0, lock);
            go(3'b000, 1'b0);
            repeat (2 * FILT) @(posedge clk);
        end
        for (i = 0; i < 16; i = i + 1) begin
            g = {$random(seed)} % 4001;
            o = $random(seed) % 2001;
            x = {$random(seed)} % 4001;
            tg = {$random(seed)} % 251;
            to = $random(seed) % 51;
            tx = {$random(seed)} % 251;
            apb(1'b1, 8'h00, g);
            apb(1'b1, 8'h04, o & 32'hfff);
            apb(1'b1, 8'h08, x);
            apb(1'b1, 8'h0c, tg);
            apb(1'b1, 8'h10, to & 32'h7f);
            apb(1'b1, 8'h14, tx);
            apb(1'b1, 8'h18, 32'h08 | ((i % 3) << 4)); // all three sources
            msel <= $random(seed);
            amv <= {$random(seed)} % 10001;
            pmv <= {$random(seed)} % 10001;
            dspd <= {$random(seed)} % 4001;
            dtrq <= {$random(seed)} % 251;
            tlen <= $random(seed);
            tlasg <= $random(seed);
            repeat (4) @(posedge clk);
            mv = msel ? amv : pmv;
            en = &(tlen | ~tlasg);
            // source 1 scales speed, source 2 torque; the rest is digital
            es = (i % 3 == 1) ? scl(g, mv, o, x) : dspd;
            et = !en ? 250 : (i % 3 == 2) ? scl(tg, mv, to, tx) : dtrq;
            chk("speed", es, spd);
            chk("lim en", en, tlon);
            chk("torque", et, trq);
            chk_reg("command", 8'h20, {et[7:0], es[11:0]});
        end
        test_done;
    end
endmodule // speed_mode_run_stop_control_test
